// *** inc/rdsel_pkg.sv ***
/*
 * constants shared by the read-port queue select block.
 * assumes a single read clock domain.
 */
`default_nettype none
package rdsel_pkg;
    // =========================================================
    // widths
    localparam int DATA_W      = 18;
    localparam int ADDR_W      = 8;
    localparam int QSEL_W      = 5;
    localparam int NUM_QUEUES  = 32;
    localparam int DEV_ID_W    = 3;
    localparam int QUAD_W      = 2;
    localparam int NUM_QUADS   = 4;
    localparam int QUAD_FLAGS  = 8;
    localparam int FIFO_DEPTH  = 8;
    // =========================================================
    // field positions in the address bus
    localparam int QSEL_LSB    = 0;
    localparam int DEV_ID_LSB  = 5;
    localparam int QUAD_LSB    = 0;
    // =========================================================
    // reset values
    localparam logic [QSEL_W-1:0] QSEL_RST  = 5'h00;
    localparam logic [QUAD_W-1:0] QUAD_RST  = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST  = 18'h00000;
    // =========================================================
    // fall-through sequence states
    typedef enum logic [1:0] {
        FT_IDLE,
        FT_OLD_WORD,
        FT_NEW_WORD
    } ft_state_t;
endpackage
`default_nettype wire

// *** rtl/rdsel_fifo.sv ***
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module rdsel_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             nrst_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign push          = in_valid_in && (cnt_q != (PW+1)'(DEPTH));
    assign pop           = out_ready_in && (cnt_q != '0);
    assign in_ready_out  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];

    // =========================================================
    // storage
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    mem_q[gi] <= '0;
                end else if (push && wr_q == PW'(gi)) begin
                    mem_q[gi] <= in_data_in;
                end
            end
        end
    endgenerate

    // =========================================================
    // pointers
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // rdsel_fifo
`default_nettype wire

// *** rtl/multi_queue_read_port_select.sv ***
/*
 * read-port queue/quadrant select with fall-through output sequencing.
 * assumes queue storage outside supplies the head word of the queue
 * on queue_index_out combinationally and advances it on queue_pop_out,
 * with per-queue almost-empty levels; strobes come from logic on
 * ref_clk_in, while programming_complete_in comes from another clock.
 * the 8-word buffer lets a stalled drain hold back queue pops,
 * at the cost of one extra edge of read latency.
 */
`timescale 1ns/1ps
`default_nettype none
module multi_queue_read_port_select
    import rdsel_pkg::*;
#(
    parameter logic [DEV_ID_W-1:0] DEVICE_ID = 3'h0  // arbitrary value
) (
    // clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  nrst_in,
    // host strobes and address
    input  wire logic                  read_enable_in,
    input  wire logic                  read_queue_select_strobe_in,
    input  wire logic                  flag_quadrant_strobe_in,
    input  wire logic [ADDR_W-1:0]     read_address_bus_in,
    input  wire logic                  polled_mode_in,
    input  wire logic                  programming_complete_in,
    // queue storage side
    output logic [QSEL_W-1:0]          queue_index_out,
    output logic                       queue_pop_out,
    input  wire logic [DATA_W-1:0]     queue_word_in,
    input  wire logic [NUM_QUEUES-1:0] queue_not_empty_in,
    input  wire logic [NUM_QUEUES-1:0] queue_almost_empty_in,
    // read data stream
    output logic                       read_data_valid_out,
    input  wire logic                  read_data_ready_in,
    output logic [DATA_W-1:0]          read_data_out,
    // flags
    output logic                       almost_empty_flag_out,
    output logic                       output_valid_flag_out,
    output logic [QUAD_FLAGS-1:0]      almost_empty_flag_bus_out,
    output logic                       flag_bus_sync_out,
    output logic                       programming_done_out,
    // expansion
    input  wire logic                  expansion_token_in,
    output logic                       expansion_token_out
);
    localparam int      OCC_W = $clog2(FIFO_DEPTH) + 1;
    logic [QSEL_W-1:0]  cur_q_q;
    logic [QSEL_W-1:0]  old_q_q;
    logic [QUAD_W-1:0]  quad_q;
    logic [QUAD_W-1:0]  poll_q;
    ft_state_t          ft_q;
    logic               dev_hit;
    logic               sel_q;
    logic               sel_quad;
    logic               fifo_pop;
    logic               room;
    logic [OCC_W-1:0]   occ_q;
    logic               fifo_valid;
    logic [DATA_W-1:0]  fifo_data;
    logic               take;
    logic [QSEL_W-1:0]  take_q;
    logic               ov_q;
    logic               ae_q;
    logic [QUAD_FLAGS-1:0] bus_q;
    logic               sync_q;
    logic               done_q;
    logic               prog_q;
    logic               prg_s1_q;
    logic               prg_s2_q;
    logic               prg_s3_q;
    logic               tok_in_q;
    logic               tok_q;
    logic [QSEL_W-1:0]  pop_q_idx;
    logic               pop_q;
    logic [QUAD_FLAGS-1:0] quad_view [NUM_QUADS];
    logic [QUAD_W-1:0]  shown_quad;

    // =========================================================
    // address decode
    assign dev_hit  = read_address_bus_in[DEV_ID_LSB +: DEV_ID_W] == DEVICE_ID;
    // a queue select is refused until programming is done
    assign sel_q    = read_queue_select_strobe_in && dev_hit && done_q;
    assign sel_quad = flag_quadrant_strobe_in && dev_hit;

    // queue select, regardless of read enable
    // old queue kept for the one forced word after a change
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cur_q_q <= QSEL_RST;
            old_q_q <= QSEL_RST;
        end else if (sel_q) begin
            old_q_q <= cur_q_q;
            cur_q_q <= read_address_bus_in[QSEL_LSB +: QSEL_W];
        end
    end

    // =========================================================
    // fall-through sequence after a queue change
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ft_q <= FT_IDLE;
        end else begin
            case (ft_q)
                FT_IDLE: begin
                    if (sel_q) begin
                        ft_q <= FT_OLD_WORD;
                    end else begin
                        ft_q <= FT_IDLE;
                    end
                end
                FT_OLD_WORD: begin
                    if (sel_q) begin
                        ft_q <= FT_OLD_WORD;
                    end else begin
                        ft_q <= FT_NEW_WORD;
                    end
                end
                FT_NEW_WORD: begin
                    if (sel_q) begin
                        ft_q <= FT_OLD_WORD;
                    end else begin
                        ft_q <= FT_IDLE;
                    end
                end
                default: begin
                    ft_q <= FT_IDLE;
                end
            endcase
        end
    end

    // forced words ignore read enable; skipped, not held, if the queue is empty or the fifo full
    always_comb begin
        take   = 1'b0;
        take_q = cur_q_q;
        case (ft_q)
            FT_OLD_WORD: begin
                take   = queue_not_empty_in[old_q_q];
                take_q = old_q_q;
            end
            FT_NEW_WORD: begin
                take   = queue_not_empty_in[cur_q_q];
                take_q = cur_q_q;
            end
            default: begin
                take   = read_enable_in && queue_not_empty_in[cur_q_q];
                take_q = cur_q_q;
            end
        endcase
        // a forced word is skipped, not held, when the buffer has no room
        take = take && room && done_q;
    end

    // pop request registered so outputs stay flop-driven
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pop_q     <= 1'b0;
            pop_q_idx <= QSEL_RST;
        end else begin
            pop_q     <= take;
            pop_q_idx <= take_q;
        end
    end

    // =========================================================
    // output buffer; a stalled drain backs up into the queue pops
    // the popped queue's head word enters on the pop edge
    rdsel_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (pop_q),
        .in_ready_out  (),
        .in_data_in    (queue_word_in),
        .out_valid_out (fifo_valid),
        .out_ready_in  (!read_data_valid_out || read_data_ready_in),
        .out_data_out  (fifo_data)
    );

    // output stage register; valid never waits on ready
    logic [DATA_W-1:0] dout_q;
    logic              dvalid_q;
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dout_q   <= DATA_RST;
            dvalid_q <= 1'b0;
        end else if (!dvalid_q || read_data_ready_in) begin
            dout_q   <= fifo_data;
            dvalid_q <= fifo_valid;
        end
    end

    // =========================================================
    // buffer occupancy; a pop lands in the buffer one edge late,
    // so the room test counts the word still on its way
    assign fifo_pop = fifo_valid && (!dvalid_q || read_data_ready_in);
    assign room     = (occ_q + OCC_W'(pop_q)) < OCC_W'(FIFO_DEPTH);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            occ_q <= '0;
        end else begin
            case ({pop_q, fifo_pop})
                2'b10:   occ_q <= occ_q + OCC_W'(1);
                2'b01:   occ_q <= occ_q - OCC_W'(1);
                default: occ_q <= occ_q;
            endcase
        end
    end

    // =========================================================
    // flag quadrant: direct latch or polled stepping
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            quad_q <= QUAD_RST;
        end else if (sel_quad) begin
            quad_q <= read_address_bus_in[QUAD_LSB +: QUAD_W];
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            poll_q <= QUAD_RST;
        end else if (polled_mode_in) begin
            // steps every edge: four edges show all 32 queues
            poll_q <= poll_q + QUAD_W'(1);
        end else begin
            poll_q <= QUAD_RST;
        end
    end

    // quadrant views, active low: low means almost empty
    genvar gq;
    generate
        for (gq = 0; gq < NUM_QUADS; gq++) begin : g_quad
            assign quad_view[gq] = ~queue_almost_empty_in[gq*QUAD_FLAGS +: QUAD_FLAGS];
        end
    endgenerate
    assign shown_quad = polled_mode_in ? poll_q : quad_q;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_q  <= '1;
            sync_q <= 1'b0;
        end else begin
            // sync marks the edge that shows quadrant zero
            bus_q  <= quad_view[shown_quad];
            sync_q <= polled_mode_in && poll_q == QUAD_RST;
        end
    end

    // =========================================================
    // almost-empty flag of the selected queue, valid flag of the output buffer
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ae_q <= 1'b0;
        end else begin
            ae_q <= queue_almost_empty_in[cur_q_q];
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ov_q <= 1'b0;
        end else begin
            ov_q <= fifo_valid;
        end
    end

    // =========================================================
    // programming done comes from the programming clock, so it
    // passes three flops and counts once the last two agree
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prg_s1_q <= 1'b0;
            prg_s2_q <= 1'b0;
            prg_s3_q <= 1'b0;
        end else begin
            prg_s1_q <= programming_complete_in;
            prg_s2_q <= prg_s1_q;
            prg_s3_q <= prg_s2_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_q <= 1'b0;
            prog_q <= 1'b1;
        end else if (prg_s2_q == prg_s3_q) begin
            done_q <= prg_s3_q;
            prog_q <= !prg_s3_q;  // low once ready
        end
    end

    // =========================================================
    // expansion token, on the same read clock as its neighbours
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tok_in_q <= 1'b0;
            tok_q    <= 1'b0;
        end else begin
            tok_in_q <= expansion_token_in;
            tok_q    <= tok_in_q && dev_hit;
        end
    end

    // =========================================================
    // outputs
    assign queue_index_out           = pop_q_idx;
    assign queue_pop_out             = pop_q;
    assign read_data_valid_out       = dvalid_q;
    assign read_data_out             = dout_q;
    assign almost_empty_flag_out     = ae_q;
    assign output_valid_flag_out     = ov_q;
    assign almost_empty_flag_bus_out = bus_q;
    assign flag_bus_sync_out         = sync_q;
    assign programming_done_out      = prog_q;
    assign expansion_token_out       = tok_q;
endmodule // multi_queue_read_port_select
`default_nettype wire

// *** dv/rdsel_asserts.sv ***
/* checker for the read-port select block.
   sees only top-level ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module rdsel_checker
    import rdsel_pkg::*;
#(
    parameter logic [DEV_ID_W-1:0] DEVICE_ID = 3'h0
) (
    input wire logic                  ref_clk_in,
    input wire logic                  nrst_in,
    input wire logic                  read_enable_in,
    input wire logic                  read_queue_select_strobe_in,
    input wire logic                  flag_quadrant_strobe_in,
    input wire logic [ADDR_W-1:0]     read_address_bus_in,
    input wire logic                  polled_mode_in,
    input wire logic                  programming_complete_in,
    input wire logic [QSEL_W-1:0]     queue_index_out,
    input wire logic                  queue_pop_out,
    input wire logic [NUM_QUEUES-1:0] queue_almost_empty_in,
    input wire logic                  read_data_valid_out,
    input wire logic                  read_data_ready_in,
    input wire logic [DATA_W-1:0]     read_data_out,
    input wire logic [QUAD_FLAGS-1:0] almost_empty_flag_bus_out,
    input wire logic                  flag_bus_sync_out,
    input wire logic                  programming_done_out,
    input wire logic                  almost_empty_flag_out,
    input wire logic                  expansion_token_in,
    input wire logic                  expansion_token_out
);
    logic              id_ok;
    logic              qsel;
    logic              fsel;
    logic [QSEL_W-1:0] sel_q;
    logic [1:0]        quad_q;
    logic [3:0]        gap_q;
    assign id_ok = read_address_bus_in[7:5] == DEVICE_ID;
    assign qsel = read_queue_select_strobe_in && id_ok && !programming_done_out;
    assign fsel = flag_quadrant_strobe_in && id_ok && !polled_mode_in;
    // =========================================================
    // helpers: last accepted selections, polled sync gap
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) sel_q <= QSEL_RST;
        else if (qsel) sel_q <= read_address_bus_in[4:0];
    end
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) quad_q <= QUAD_RST;
        else if (fsel) quad_q <= read_address_bus_in[1:0];
    end
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) gap_q <= 4'h0;
        else if (!polled_mode_in || flag_bus_sync_out) gap_q <= 4'h0;
        else if (gap_q != 4'hF) gap_q <= gap_q + 4'h1;
    end
    // =========================================================
    // properties
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    AST_PROG_DONE: assert property (programming_complete_in [*4] |=> !programming_done_out)
        else $error("programming done not low");
    AST_SEL_POP: assert property (qsel |-> ##[1:3] queue_pop_out)
        else $error("no pop after queue select");
    AST_SEL_INDEX: assert property (qsel |-> ##[2:3] queue_index_out == sel_q)
        else $error("selected queue not taken");
    AST_ID_IGNORE: assert property (read_queue_select_strobe_in && !id_ok |-> ##3 queue_index_out == sel_q)
        else $error("foreign select acted on");
    AST_QUAD: assert property (fsel |-> ##2 almost_empty_flag_bus_out == ~queue_almost_empty_in[quad_q*8 +: 8])
        else $error("quadrant flags wrong");
    AST_SYNC_QUAD0: assert property (polled_mode_in && $past(polled_mode_in) && flag_bus_sync_out
        && $stable(queue_almost_empty_in) |-> almost_empty_flag_bus_out == ~queue_almost_empty_in[7:0])
        else $error("sync not on quadrant zero");
    AST_SYNC_GAP: assert property (gap_q <= 4'h5)
        else $error("polled bus not cycling");
    AST_STREAM_HOLD: assert property (read_data_valid_out && !read_data_ready_in |=>
        read_data_valid_out && $stable(read_data_out))
        else $error("stream word dropped");
    AST_NO_STRAY_POP: assert property ((!read_enable_in && !read_queue_select_strobe_in) [*6] |=> !queue_pop_out)
        else $error("pop without read");
    AST_AE_FLAG: assert property (almost_empty_flag_out == $past(queue_almost_empty_in[sel_q]))
        else $error("almost-empty flag not of selected queue");
    AST_TOKEN: assert property (expansion_token_out == ($past(expansion_token_in, 2) && $past(id_ok)))
        else $error("expansion token wrong");
endmodule // rdsel_checker
bind multi_queue_read_port_select rdsel_checker #(.DEVICE_ID(DEVICE_ID)) i_chk (.*);
`default_nettype wire

// *** dv/queue_store_model.sv ***
/* queue storage stand-in: 32 queues of counting words.
   assumes pops arrive from the block on ref_clk_in. */
`timescale 1ns/1ps
`default_nettype none
module queue_store_model
    import rdsel_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              nrst_in,
    input  wire logic [QSEL_W-1:0] queue_index_in,
    input  wire logic              queue_pop_in,
    output logic      [DATA_W-1:0] queue_word_out
);
    logic [12:0] ptr_q [NUM_QUEUES];
    // word carries its queue so a wrong-queue read shows
    assign queue_word_out = {queue_index_in, ptr_q[queue_index_in]};
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NUM_QUEUES; i++) ptr_q[i] <= 13'h0000;
        end else if (queue_pop_in) begin
            ptr_q[queue_index_in] <= ptr_q[queue_index_in] + 13'h0001;
        end
    end
endmodule // queue_store_model
`default_nettype wire

// *** dv/multi_queue_read_port_select_test.sv ***
/* self-checking bench for the read-port select block.
   assumes the storage model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
module multi_queue_read_port_select_test;
    import rdsel_pkg::*;
    localparam logic [2:0] DEV = 3'h2;  // arbitrary value
    logic ref_clk_in = 1'b0, nrst_in = 1'b0, ren = 1'b0, qstb = 1'b0, fstb = 1'b0, tokin = 1'b0;
    logic polled = 1'b0, pdone = 1'b0, rdy = 1'b1, pop, vld, oflag, aef, sync, prog, tok;
    logic [ADDR_W-1:0]     addr = 8'h00;
    logic [NUM_QUEUES-1:0] ae = 32'h00000000;
    logic [QSEL_W-1:0]     qidx, cur = 5'h00;
    logic [DATA_W-1:0]     word, rdata;
    logic [QUAD_FLAGS-1:0] fbus;
    logic [15:0]           seed = 16'h5275;
    logic [DATA_W-1:0]     exp_q [$];
    logic [12:0]           ptr [NUM_QUEUES] = '{default: 13'h0000};
    int                    err_total = 0, checks = 0, n;
    multi_queue_read_port_select #(.DEVICE_ID(DEV)) i_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .read_enable_in(ren), .read_queue_select_strobe_in(qstb), .flag_quadrant_strobe_in(fstb),
        .read_address_bus_in(addr), .polled_mode_in(polled), .programming_complete_in(pdone),
        .queue_index_out(qidx), .queue_pop_out(pop), .queue_word_in(word),
        .queue_not_empty_in(32'hFFFFFFFF), .queue_almost_empty_in(ae), .read_data_valid_out(vld),
        .read_data_ready_in(rdy), .read_data_out(rdata), .almost_empty_flag_out(aef),
        .output_valid_flag_out(oflag), .almost_empty_flag_bus_out(fbus), .flag_bus_sync_out(sync),
        .programming_done_out(prog), .expansion_token_in(tokin), .expansion_token_out(tok));
    queue_store_model i_store (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .queue_index_in(qidx),
        .queue_pop_in(pop), .queue_word_out(word));
    // =========================================================
    // helpers
    always #50 ref_clk_in = ~ref_clk_in;  // free running
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("mismatches=%0d compares=%0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_in);
        #5;
    endtask
    task automatic note(input logic [QSEL_W-1:0] q);
        exp_q.push_back({q, ptr[q]});
        ptr[q]++;
    endtask
    // one queue change, strobe for a single cycle only
    task automatic select(input logic [QSEL_W-1:0] q);
        addr = {DEV, q};
        qstb = 1'b1;
        tick(1);
        qstb = 1'b0;
        note(cur);
        note(q);
        cur = q;
        tick(4);
    endtask
    // reads spaced one idle cycle so the storage head settles
    task automatic rd(input int k);
        repeat (k) begin
            ren = 1'b1;
            tick(1);
            ren = 1'b0;
            note(cur);
            tick(1);
        end
    endtask
    // =========================================================
    // monitor: oldest note against each accepted word
    always @(posedge ref_clk_in) begin
        if (nrst_in && vld === 1'b1 && rdy) begin
            if (exp_q.size() == 0) check(rdata, 18'h3FFFF);
            else check(rdata, exp_q.pop_front());
        end
    end
    // =========================================================
    // main sequence
    initial begin
        tick(20);
        nrst_in = 1'b1;
        tick(3);
        check({17'h0, prog}, 18'h00001);
        pdone = 1'b1;
        n = 0;
        while (prog !== 1'b0 && n < 8) begin tick(1); n++; end
        check({17'h0, prog}, 18'h00000);
        if (n == 8) results();
        select(5'h1F);
        rd(2);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            tokin = seed[7];
            select(seed[4:0]);
            rd(int'(seed[6:5]));
        end
        addr = {3'h5, 5'h03};
        qstb = 1'b1;
        tick(1);
        qstb = 1'b0;
        tick(4);
        rd(1);  // foreign id, queue unchanged
        seed = lfsr(seed);
        ae = {seed, ~seed};
        for (int i = 0; i < NUM_QUADS; i++) begin
            seed = lfsr(seed);
            addr = {DEV, seed[2:0], i[1:0]};
            fstb = 1'b1;
            tick(1);
            fstb = 1'b0;
            tick(2);
            check({10'h000, fbus}, {10'h000, ~ae[i*8 +: 8]});
        end
        polled = 1'b1;
        n = 0;
        while (sync !== 1'b1 && n < 8) begin tick(1); n++; end
        check({17'h0, sync}, 18'h00001);
        if (n == 8) results();
        tick(12);
        polled = 1'b0;
        rdy = 1'b0;
        rd(8);  // eight reads while stalled: one word in the output stage, seven in the buffer
        check({17'h0, vld}, 18'h00001);
        check({17'h0, oflag}, 18'h00001);
        rdy = 1'b1;
        n = 0;
        while (exp_q.size() != 0 && n < 60) begin tick(1); n++; end
        check(18'(exp_q.size()), 18'h00000);
        results();
    end
endmodule // multi_queue_read_port_select_test
`default_nettype wire
